// File: core/pefc_pkg.sv
// Purpose: Shared constants and types for the event filter configuration.
// Assumes: 64-bit configuration words, 31 event counters.
// Notes: Field positions and access codes are held here only.
package pefc_pkg;
    localparam int PEFC_NUM_CTR = 31;
    localparam int PEFC_IDX_W = 5;
    localparam int PEFC_REG_W = 64;
    localparam int PEFC_LOW_W = 32;
    localparam int PEFC_P_BIT = 31;
    localparam int PEFC_U_BIT = 30;
    localparam int PEFC_NSK_BIT = 29;
    localparam int PEFC_NSU_BIT = 28;
    localparam int PEFC_HYP_BIT = 27;
    localparam int PEFC_EL3_BIT = 26;
    localparam int PEFC_THR_BIT = 25;
    localparam int PEFC_SEL2_BIT = 24;
    localparam int PEFC_TX_BIT = 23;
    localparam int PEFC_RLK_BIT = 22;
    localparam int PEFC_RLU_BIT = 21;
    localparam int PEFC_RLH_BIT = 20;
    localparam int PEFC_EVT_MSB = 9;
    localparam logic [5:0] PEFC_EC_SYSREG = 6'h18;
    localparam logic [63:0] PEFC_REG_RESET = 64'h0;
    localparam logic [1:0] PEFC_EL0 = 2'h0;
    localparam logic [1:0] PEFC_EL1 = 2'h1;
    localparam logic [1:0] PEFC_EL2 = 2'h2;
    localparam logic [1:0] PEFC_EL3 = 2'h3;
    localparam logic [1:0] PEFC_SS_SEC = 2'h0;
    localparam logic [1:0] PEFC_SS_NS = 2'h1;
    localparam logic [1:0] PEFC_SS_RL = 2'h3;

    // Features present in this build.
    typedef struct packed {
        logic base_perf_monitor_feature;
        logic el2_present;
        logic el3_present;
        logic secure_el2_feature;
        logic multithread_monitor_feature;
        logic transactional_memory_feature;
        logic realm_feature;
    } pefc_feat_t;

    // Trap controls seen by the cycle filter write check.
    typedef struct packed {
        logic user_access_enable;
        logic host_trap_general;
        logic el2_enabled;
        logic el2_monitor_trap;
        logic el3_monitor_trap;
        logic fine_grained_trap_allow;
        logic fine_grained_write_trap;
        logic halted;
        logic secure_debug_disabled;
    } pefc_trap_ctl_t;

    // Outcome of a system register access.
    typedef struct packed {
        logic done;
        logic undef;
        logic trap;
        logic [1:0] target_el;
        logic [5:0] ec;
    } pefc_resp_t;

    typedef enum logic [2:0] {
        PEFC_IDLE = 3'h1,
        PEFC_RESP = 3'h2,
        PEFC_HOLD = 3'h4
    } pefc_state_t;
endpackage : pefc_pkg

// File: core/pefc_filter.sv
// Purpose: Decides whether one counter may count in the current context.
// Assumes: Configuration word already masked for absent features.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module pefc_filter
    import pefc_pkg::*;
(
    input wire logic [31:0] cfg,
    input wire logic [1:0] cur_el,
    input wire logic [1:0] sec_state,
    input wire logic in_transaction,
    input wire logic thread_mt_ok,
    input wire logic event_in,
    input wire logic event_other_pe,
    input wire pefc_feat_t feat,
    output logic allow
);
    logic el_ok;
    logic src_ok;

    // Exception level and security state qualifiers.
    always_comb
    begin
        el_ok = 1'b0;
        case (cur_el)
            PEFC_EL0:
            begin
                el_ok = !cfg[PEFC_U_BIT];
                if (feat.el3_present && sec_state == PEFC_SS_NS)
                    el_ok = cfg[PEFC_NSU_BIT] == cfg[PEFC_U_BIT];
                if (feat.realm_feature && sec_state == PEFC_SS_RL)
                    el_ok = cfg[PEFC_RLU_BIT] == cfg[PEFC_U_BIT];
            end
            PEFC_EL1:
            begin
                el_ok = !cfg[PEFC_P_BIT];
                if (feat.el3_present && sec_state == PEFC_SS_NS)
                    el_ok = cfg[PEFC_NSK_BIT] == cfg[PEFC_P_BIT];
                if (feat.realm_feature && sec_state == PEFC_SS_RL)
                    el_ok = cfg[PEFC_RLK_BIT] == cfg[PEFC_P_BIT];
            end
            PEFC_EL2:
            begin
                el_ok = feat.el2_present && cfg[PEFC_HYP_BIT];
                if (feat.secure_el2_feature && feat.el3_present
                    && sec_state == PEFC_SS_SEC)
                    el_ok = cfg[PEFC_SEL2_BIT] != cfg[PEFC_HYP_BIT];
                if (feat.realm_feature && sec_state == PEFC_SS_RL)
                    el_ok = cfg[PEFC_RLH_BIT] != cfg[PEFC_HYP_BIT];
            end
            PEFC_EL3:
                el_ok = feat.el3_present
                    && cfg[PEFC_EL3_BIT] == cfg[PEFC_P_BIT];
            default:
                el_ok = 1'b0;
        endcase
    end

    // Sibling thread events only pass when the scope bit is live.
    assign src_ok = event_in
        || (event_other_pe && thread_mt_ok && cfg[PEFC_THR_BIT]);

    // Every applicable qualifier must agree before a count.
    assign allow = src_ok && el_ok
        && !(in_transaction && cfg[PEFC_TX_BIT]);
endmodule : pefc_filter
`default_nettype wire

// File: core/pefc_top.sv
// Purpose: Event filter configuration bank and cycle filter write checks.
// Assumes: Accesses arrive as single-cycle requests from the core pipeline.
// Notes: Fields of absent features read as zero and drop writes.
//
// Behaviour
// - Thirty-one 64-bit configuration registers, one each.
// - Low word shared by both access views.
// - Without base feature, system accesses are undefined.
// - Privileged bit set suppresses EL1 counting.
// - User bit set suppresses EL0 counting.
// - Non-secure EL1 counts when kernel bit matches.
// - Non-secure EL0 counts when user bit matches.
// - Hypervisor bit set allows EL2 counting.
// - EL3 counts when its bit matches privileged.
// - Thread scope bit widens to sibling elements.
// - Disabled thread feature treats scope as zero.
// - Secure EL2 counts when bit differs from hypervisor.
// - Transactional bit set suppresses transactional counting.
// - Realm EL1 counts when kernel bit matches.
// - Fields unknown after reset (reset loads zero here); absent fields zero.
// - EL0 write without user access traps, class 0x18.
// - Fine-grained write trap sends write to EL2.
// - Monitor traps go to EL2 or EL3.
// - EL3 writes always update cycle filter.
// - Privileged filter bit sits at position 31.
// - Realm EL0 counts when user bit matches.
// - Realm EL2 counts when bit differs from hypervisor.
// - Bits nine to zero hold event number.
`timescale 1ns/1ps
`default_nettype none
module pefc_top
    import pefc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire pefc_feat_t feat,
    input wire logic thread_feature_enabled,
    input wire pefc_trap_ctl_t trap_ctl,
    input wire logic [1:0] cur_el,
    input wire logic [1:0] sec_state,
    input wire logic in_transaction,
    input wire logic sys_req,
    input wire logic sys_write,
    input wire logic sys_cycle_sel,
    input wire logic [4:0] sys_index,
    input wire logic [63:0] sys_wdata,
    input wire logic ext_req,
    input wire logic ext_write,
    input wire logic [4:0] ext_index,
    input wire logic [31:0] ext_wdata,
    input wire logic [30:0] event_in,
    input wire logic [30:0] event_other_pe,
    output logic [63:0] sys_rdata,
    output pefc_resp_t sys_resp,
    output logic [31:0] ext_rdata,
    output logic ext_ack,
    output logic [30:0] count_en,
    output logic [31:0] cycle_filter_config
);
    logic [63:0] event_filter_config_r [PEFC_NUM_CTR];
    logic [31:0] cycle_filter_config_r;
    logic [63:0] wmask;
    logic [63:0] sys_rdata_r;
    logic [31:0] ext_rdata_r;
    logic ext_ack_r;
    pefc_resp_t resp_nxt;
    pefc_resp_t sys_resp_r;
    logic [30:0] count_en_r;
    logic [30:0] allow;
    logic sys_ok;
    logic sys_hit;
    logic ext_hit;
    logic mt_ok;
    pefc_state_t state_r;
    pefc_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Writable bit mask from the features present in this build.
    function automatic logic [63:0] field_mask(input pefc_feat_t f);
        logic [63:0] m;
        m = 64'h0;
        m[PEFC_P_BIT] = 1'b1;
        m[PEFC_U_BIT] = 1'b1;
        m[PEFC_NSK_BIT] = f.el3_present;
        m[PEFC_NSU_BIT] = f.el3_present;
        m[PEFC_HYP_BIT] = f.el2_present;
        m[PEFC_EL3_BIT] = f.el3_present;
        m[PEFC_THR_BIT] = f.multithread_monitor_feature;
        m[PEFC_SEL2_BIT] = f.secure_el2_feature && f.el3_present;
        m[PEFC_TX_BIT] = f.transactional_memory_feature;
        m[PEFC_RLK_BIT] = f.realm_feature;
        m[PEFC_RLU_BIT] = f.realm_feature;
        m[PEFC_RLH_BIT] = f.realm_feature;
        m[PEFC_EVT_MSB:0] = '1;
        return m;
    endfunction : field_mask

    // A counter index names a register only below the counter count.
    function automatic logic idx_valid(input logic [4:0] idx);
        return idx < 5'(PEFC_NUM_CTR);
    endfunction : idx_valid

    assign wmask = field_mask(feat);
    assign mt_ok = thread_feature_enabled;
    assign sys_ok = sys_req && feat.base_perf_monitor_feature;
    assign sys_hit = sys_ok && !sys_cycle_sel && idx_valid(sys_index);
    assign ext_hit = ext_req && feat.base_perf_monitor_feature
        && idx_valid(ext_index);

    ////////////////////////////////////////////////////////////////////////
    // Cycle filter write trap check, in priority order.
    always_comb
    begin
        resp_nxt = '0;
        resp_nxt.done = sys_req;
        resp_nxt.ec = PEFC_EC_SYSREG;
        if (!feat.base_perf_monitor_feature)
            resp_nxt.undef = sys_req;
        else if (sys_req && sys_write && sys_cycle_sel
                 && cur_el != PEFC_EL3)
        begin
            // A halted core with secure debug off and the EL3 monitor trap set outranks every trap.
            if (feat.el3_present && trap_ctl.el3_monitor_trap
                && trap_ctl.halted && trap_ctl.secure_debug_disabled)
                resp_nxt.undef = 1'b1;
            else if (cur_el == PEFC_EL0 && !trap_ctl.user_access_enable)
            begin
                resp_nxt.trap = 1'b1;
                resp_nxt.target_el = (trap_ctl.el2_enabled
                    && trap_ctl.host_trap_general) ? PEFC_EL2 : PEFC_EL1;
            end
            else if (cur_el != PEFC_EL2 && trap_ctl.el2_enabled
                     && (!feat.el3_present
                         || trap_ctl.fine_grained_trap_allow)
                     && trap_ctl.fine_grained_write_trap)
            begin
                resp_nxt.trap = 1'b1;
                resp_nxt.target_el = PEFC_EL2;
            end
            else if (cur_el != PEFC_EL2 && trap_ctl.el2_enabled
                     && trap_ctl.el2_monitor_trap)
            begin
                resp_nxt.trap = 1'b1;
                resp_nxt.target_el = PEFC_EL2;
            end
            else if (feat.el3_present && trap_ctl.el3_monitor_trap)
            begin
                if (trap_ctl.halted && trap_ctl.secure_debug_disabled)
                    resp_nxt.undef = 1'b1;
                else
                begin
                    resp_nxt.trap = 1'b1;
                    resp_nxt.target_el = PEFC_EL3;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response sequencer: one answer per request, one cycle later.
    always_comb
    begin
        case (state_r)
            PEFC_IDLE:
                state_nxt = sys_req ? PEFC_RESP : PEFC_IDLE;
            PEFC_RESP:
                state_nxt = sys_req ? PEFC_RESP : PEFC_IDLE;
            default:
                state_nxt = PEFC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_r <= PEFC_IDLE;
        else
            state_r <= state_nxt;
    end

    // Response registers.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            sys_resp_r <= '0;
        else
            sys_resp_r <= resp_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event configuration storage; the system view wins a same-index clash.
    generate
        for (genvar i = 0; i < PEFC_NUM_CTR; i++)
        begin : g_cfg
            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                    event_filter_config_r[i] <= PEFC_REG_RESET;
                else if (sys_hit && sys_write
                         && sys_index == 5'(i))
                    event_filter_config_r[i] <= sys_wdata & wmask;
                else if (ext_hit && ext_write && ext_index == 5'(i))
                    event_filter_config_r[i][31:0] <=
                        ext_wdata & wmask[31:0];
            end

            pefc_filter u_filter
            (
                .cfg(event_filter_config_r[i][31:0]),
                .cur_el(cur_el),
                .sec_state(sec_state),
                .in_transaction(in_transaction),
                .thread_mt_ok(mt_ok),
                .event_in(event_in[i]),
                .event_other_pe(event_other_pe[i]),
                .feat(feat),
                .allow(allow[i])
            );
        end
    endgenerate

    // Cycle filter register; EL3 writes skip every check.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cycle_filter_config_r <= PEFC_REG_RESET[31:0];
        else if (sys_ok && sys_write && sys_cycle_sel
                 && !resp_nxt.trap && !resp_nxt.undef)
            cycle_filter_config_r <= sys_wdata[31:0] & wmask[31:0]
                & 32'hFC000000;
    end

    // Read data for both views.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sys_rdata_r <= 64'h0;
            ext_rdata_r <= 32'h0;
            ext_ack_r <= 1'b0;
        end
        else
        begin
            sys_rdata_r <= sys_cycle_sel ? {32'h0, cycle_filter_config_r}
                : (sys_hit ? event_filter_config_r[sys_index] : 64'h0);
            ext_rdata_r <= ext_hit ? event_filter_config_r[ext_index][31:0]
                : 32'h0;
            ext_ack_r <= ext_req;
        end
    end

    // Registered count enables.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            count_en_r <= 31'h0;
        else
            count_en_r <= allow;
    end

    assign sys_rdata = sys_rdata_r;
    assign sys_resp = sys_resp_r;
    assign ext_rdata = ext_rdata_r;
    assign ext_ack = ext_ack_r;
    assign count_en = count_en_r;
    assign cycle_filter_config = cycle_filter_config_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Every access is answered exactly one cycle after it is taken.
    done_once_a: assert property (
        sys_req |=> sys_resp.done && state_r == PEFC_RESP)
        else $error("system access not answered");
    ext_ack_a: assert property (
        ext_req |=> ext_ack)
        else $error("external access not acknowledged");
    bad_index_a: assert property (
        sys_req && !sys_cycle_sel && sys_index == 5'h1F
        |=> sys_rdata == 64'h0)
        else $error("unimplemented counter index read nonzero");
    no_base_undef_a: assert property (
        sys_req && !feat.base_perf_monitor_feature |=> sys_resp.undef)
        else $error("access without base feature not undefined");
    ext_view_a: assert property (
        ext_hit && !ext_write && !(sys_hit && sys_write)
        |=> ext_rdata == event_filter_config_r[$past(ext_index)][31:0])
        else $error("external view differs");
    absent_zero_a: assert property (
        !feat.realm_feature && $stable(feat)
        |=> event_filter_config_r[0][PEFC_RLK_BIT] == 1'b0)
        else $error("absent realm field not zero");

    // Cycle filter write permission checks.
    user_trap_a: assert property (
        sys_req && sys_write && sys_cycle_sel
        && feat.base_perf_monitor_feature && cur_el == PEFC_EL0
        && !trap_ctl.user_access_enable && !trap_ctl.halted
        |=> sys_resp.trap && sys_resp.ec == PEFC_EC_SYSREG)
        else $error("EL0 cycle filter write did not trap");
    fine_trap_a: assert property (
        resp_nxt.trap && cur_el == PEFC_EL1
        && trap_ctl.fine_grained_write_trap && trap_ctl.el2_enabled
        && (!feat.el3_present || trap_ctl.fine_grained_trap_allow)
        |=> sys_resp.target_el == PEFC_EL2)
        else $error("fine-grained trap not to EL2");
    halt_undef_a: assert property (
        sys_req && sys_write && sys_cycle_sel && cur_el != PEFC_EL3
        && feat.base_perf_monitor_feature && feat.el3_present
        && trap_ctl.el3_monitor_trap && trap_ctl.halted
        && trap_ctl.secure_debug_disabled
        |=> sys_resp.undef && !sys_resp.trap)
        else $error("halted monitor trap not undefined");
    el3_write_a: assert property (
        sys_req && sys_write && sys_cycle_sel
        && feat.base_perf_monitor_feature && cur_el == PEFC_EL3
        |=> !sys_resp.trap
        && cycle_filter_config[PEFC_P_BIT] == $past(sys_wdata[PEFC_P_BIT]))
        else $error("EL3 cycle filter write lost");

    // Counting filter checks on counter two, the one the tests drive.
    el1_block_a: assert property (
        cur_el == PEFC_EL1 && sec_state == PEFC_SS_SEC
        && event_filter_config_r[2][PEFC_P_BIT] |=> !count_en[2])
        else $error("EL1 counted with privileged bit set");
    nsk_block_a: assert property (
        cur_el == PEFC_EL1 && sec_state == PEFC_SS_NS && feat.el3_present
        && event_filter_config_r[2][PEFC_NSK_BIT]
            != event_filter_config_r[2][PEFC_P_BIT]
        |=> !count_en[2])
        else $error("non-secure EL1 counted with kernel bit mismatch");
    hyp_count_a: assert property (
        cur_el == PEFC_EL2 && event_in[2] && sec_state == PEFC_SS_NS
        && feat.el2_present && !in_transaction
        && event_filter_config_r[2][PEFC_HYP_BIT] |=> count_en[2])
        else $error("EL2 event not counted");
    thr_block_a: assert property (
        !event_in[2] && !event_filter_config_r[2][PEFC_THR_BIT]
        |=> !count_en[2])
        else $error("sibling event counted with thread scope clear");
    tx_block_a: assert property (
        in_transaction && event_filter_config_r[2][PEFC_TX_BIT]
        |=> !count_en[2])
        else $error("transactional event counted");

    // Covers of the main scenarios.
    cov_trap_c: cover property (sys_resp.trap);
    cov_undef_c: cover property (sys_resp.undef);
    cov_count_c: cover property (count_en[2]);
    cov_ext_c: cover property (ext_ack && ext_rdata != 32'h0);
    cov_cycle_c: cover property (sys_resp.done && !sys_resp.trap);
endmodule : pefc_top
`default_nettype wire

// File: tb/pefc_top_test.sv
// Purpose: Self-checking bench for the event filter configuration bank.
// Assumes: Inputs change on the falling edge; answers stand one cycle.
// Notes: A reset value of zero stands in for the unknown reset content.
`timescale 1ns/1ps
`default_nettype none
module pefc_top_test
    import pefc_pkg::*;
;
    logic ref_clk;
    logic rst_n;
    pefc_feat_t feat;
    logic thr_en;
    pefc_trap_ctl_t tc;
    logic [1:0] cur_el;
    logic [1:0] sec_state;
    logic in_tx;
    logic sys_req;
    logic sys_write;
    logic sys_cyc;
    logic [4:0] sys_index;
    logic [63:0] sys_wdata;
    logic ext_req;
    logic ext_write;
    logic [4:0] ext_index;
    logic [31:0] ext_wdata;
    logic [30:0] event_in;
    logic [30:0] event_oth;
    logic [63:0] sys_rdata;
    pefc_resp_t sys_resp;
    logic [31:0] ext_rdata;
    logic ext_ack;
    logic [30:0] count_en;
    logic [31:0] cyc_cfg;
    logic [63:0] rd;
    pefc_resp_t rsp;
    int mismatches;
    int n_checks;

    ////////////////////////////////////////////////////////////////////////
    // Device under test with every input driven by the bench.
    pefc_top i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .feat(feat),
        .thread_feature_enabled(thr_en), .trap_ctl(tc), .cur_el(cur_el),
        .sec_state(sec_state), .in_transaction(in_tx), .sys_req(sys_req),
        .sys_write(sys_write), .sys_cycle_sel(sys_cyc),
        .sys_index(sys_index), .sys_wdata(sys_wdata), .ext_req(ext_req),
        .ext_write(ext_write), .ext_index(ext_index),
        .ext_wdata(ext_wdata), .event_in(event_in),
        .event_other_pe(event_oth), .sys_rdata(sys_rdata),
        .sys_resp(sys_resp), .ext_rdata(ext_rdata), .ext_ack(ext_ack),
        .count_en(count_en), .cycle_filter_config(cyc_cfg)
    );

    // Free-running 10 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a difference at once.
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    // One system access; the answer is sampled the cycle after it is taken.
    task automatic sys_acc(input logic wr, input logic cyc,
                           input logic [4:0] idx, input logic [63:0] d);
        @(negedge ref_clk);
        sys_req = 1'b1;
        sys_write = wr;
        sys_cyc = cyc;
        sys_index = idx;
        sys_wdata = d;
        @(negedge ref_clk);
        rd = sys_rdata;
        rsp = sys_resp;
        sys_req = 1'b0;
    endtask : sys_acc

    // One external debug access of the low word.
    task automatic ext_acc(input logic wr, input logic [4:0] idx,
                           input logic [31:0] d);
        @(negedge ref_clk);
        ext_req = 1'b1;
        ext_write = wr;
        ext_index = idx;
        ext_wdata = d;
        @(negedge ref_clk);
        chk({63'h0, ext_ack}, 64'h1);
        rd = {32'h0, ext_rdata};
        ext_req = 1'b0;
    endtask : ext_acc

    // Programs counter two, applies a context and checks every enable.
    // Flags f, from the top: transactional, own event, sibling event,
    // thread feature enabled and the expected enable.
    task automatic cnt_case(input logic [31:0] cfg, input logic [1:0] el,
                            input logic [1:0] ss, input logic [4:0] f);
        sys_acc(1'b1, 1'b0, 5'h02, {32'h0, cfg});
        cur_el = el;
        sec_state = ss;
        in_tx = f[4];
        thr_en = f[1];
        event_in = {28'h0, f[3], 2'h0};
        event_oth = {28'h0, f[2], 2'h0};
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({33'h0, count_en}, {33'h0, 28'h0, f[0], 2'h0});
    endtask : cnt_case

    // Writes the cycle filter; exp is undefined, trap and target level.
    task automatic cyc_case(input logic [1:0] el, input logic [8:0] t,
                            input logic [31:0] d, input logic [3:0] exp,
                            input logic [31:0] cfg);
        tc = t;
        cur_el = el;
        sys_acc(1'b1, 1'b1, 5'h00, {32'h0, d});
        if (exp[3])
            chk({62'h0, rsp.undef, rsp.trap}, {62'h0, exp[3:2]});
        else
            chk({60'h0, rsp.undef, rsp.trap, rsp.target_el},
                {60'h0, exp});
        if (exp[2])
            chk({58'h0, rsp.ec}, {58'h0, PEFC_EC_SYSREG});
        chk({32'h0, cyc_cfg}, {32'h0, cfg});
    endtask : cyc_case

    ////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial
    begin
        mismatches = 0;
        n_checks = 0;
        rst_n = 1'b0;
        feat = 7'h7F;
        thr_en = 1'b1;
        tc = 9'h100;
        cur_el = PEFC_EL3;
        sec_state = PEFC_SS_SEC;
        in_tx = 1'b0;
        sys_req = 1'b0;
        sys_write = 1'b0;
        sys_cyc = 1'b0;
        sys_index = 5'h00;
        sys_wdata = 64'h0;
        ext_req = 1'b0;
        ext_write = 1'b0;
        ext_index = 5'h00;
        ext_wdata = 32'h0;
        event_in = 31'h0;
        event_oth = 31'h0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        sys_acc(1'b0, 1'b0, 5'h00, 64'h0);
        chk(rd, 64'h0);
        chk({63'h0, rsp.done}, 64'h1);
        sys_acc(1'b1, 1'b0, 5'h00, 64'h0000_0000_A5A0_0155);
        sys_acc(1'b1, 1'b0, 5'h1E, 64'h0000_0000_5A50_02AA);
        sys_acc(1'b0, 1'b0, 5'h00, 64'h0);
        chk(rd, 64'h0000_0000_A5A0_0155);
        sys_acc(1'b0, 1'b0, 5'h1E, 64'h0);
        chk(rd, 64'h0000_0000_5A50_02AA);
        sys_acc(1'b1, 1'b0, 5'h1F, 64'h0000_0000_FFF0_03FF);
        sys_acc(1'b0, 1'b0, 5'h1F, 64'h0);
        chk(rd, 64'h0);
        ext_acc(1'b1, 5'h03, 32'hC3C0_0123);
        sys_acc(1'b0, 1'b0, 5'h03, 64'h0);
        chk(rd, 64'h0000_0000_C3C0_0123);
        ext_acc(1'b0, 5'h1E, 32'h0);
        chk(rd, 64'h0000_0000_5A50_02AA);
        feat = 7'h40;
        sys_acc(1'b1, 1'b0, 5'h04, 64'h0000_0000_FFF0_03FF);
        sys_acc(1'b0, 1'b0, 5'h04, 64'h0);
        chk(rd, 64'h0000_0000_C000_03FF);
        feat = 7'h00;
        sys_acc(1'b0, 1'b0, 5'h00, 64'h0);
        chk({63'h0, rsp.undef}, 64'h1);
        feat = 7'h7F;
        cnt_case(32'h0, PEFC_EL1, PEFC_SS_NS, 5'b01011);
        cnt_case(32'h2000_0000, PEFC_EL1, PEFC_SS_NS, 5'b01010);
        cnt_case(32'h8000_0000, PEFC_EL1, PEFC_SS_SEC, 5'b01010);
        cnt_case(32'h1000_0000, PEFC_EL0, PEFC_SS_NS, 5'b01010);
        cnt_case(32'h4000_0000, PEFC_EL0, PEFC_SS_SEC, 5'b01010);
        cnt_case(32'h0, PEFC_EL0, PEFC_SS_SEC, 5'b01011);
        cnt_case(32'h0, PEFC_EL2, PEFC_SS_NS, 5'b01010);
        cnt_case(32'h0800_0000, PEFC_EL2, PEFC_SS_NS, 5'b01011);
        cnt_case(32'h0800_0000, PEFC_EL2, PEFC_SS_SEC, 5'b01011);
        cnt_case(32'h0900_0000, PEFC_EL2, PEFC_SS_SEC, 5'b01010);
        cnt_case(32'h0, PEFC_EL3, PEFC_SS_SEC, 5'b01011);
        cnt_case(32'h0400_0000, PEFC_EL3, PEFC_SS_SEC, 5'b01010);
        cnt_case(32'h0040_0000, PEFC_EL1, PEFC_SS_RL, 5'b01010);
        cnt_case(32'h0, PEFC_EL1, PEFC_SS_RL, 5'b01011);
        cnt_case(32'h0020_0000, PEFC_EL0, PEFC_SS_RL, 5'b01010);
        cnt_case(32'h0800_0000, PEFC_EL2, PEFC_SS_RL, 5'b01011);
        cnt_case(32'h0810_0000, PEFC_EL2, PEFC_SS_RL, 5'b01010);
        cnt_case(32'h0080_0000, PEFC_EL1, PEFC_SS_SEC, 5'b11010);
        cnt_case(32'h0080_0000, PEFC_EL1, PEFC_SS_SEC, 5'b01011);
        cnt_case(32'h0, PEFC_EL1, PEFC_SS_SEC, 5'b11011);
        cnt_case(32'h0, PEFC_EL1, PEFC_SS_SEC, 5'b00010);
        cnt_case(32'h0, PEFC_EL1, PEFC_SS_SEC, 5'b00110);
        cnt_case(32'h0200_0000, PEFC_EL1, PEFC_SS_SEC, 5'b00111);
        cnt_case(32'h0200_0000, PEFC_EL1, PEFC_SS_SEC, 5'b00100);
        cyc_case(PEFC_EL3, 9'h1FF, 32'hFC00_0000, 4'h0, 32'hFC00_0000);
        cyc_case(PEFC_EL0, 9'h000, 32'h0, 4'h5, 32'hFC00_0000);
        cyc_case(PEFC_EL0, 9'h0C0, 32'h0, 4'h6, 32'hFC00_0000);
        cyc_case(PEFC_EL1, 9'h14C, 32'h0, 4'h6, 32'hFC00_0000);
        cyc_case(PEFC_EL1, 9'h160, 32'h0, 4'h6, 32'hFC00_0000);
        cyc_case(PEFC_EL2, 9'h110, 32'h0, 4'h7, 32'hFC00_0000);
        cyc_case(PEFC_EL2, 9'h113, 32'h0, 4'h8, 32'hFC00_0000);
        cyc_case(PEFC_EL0, 9'h013, 32'h0, 4'h8, 32'hFC00_0000);
        cyc_case(PEFC_EL3, 9'h1FF, 32'h0, 4'h0, 32'h0);
        stop_test();
    end

    // Watchdog that cuts a hang short well after the tests should end.
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
endmodule : pefc_top_test
`default_nettype wire
